// file: pkg/laser_ctrl_pkg.sv
/*
 * Laser driver control constants: modes, sequencer states, counts.
 * Assumes a 125 MHz core clock.
 */
package laser_ctrl_pkg;

    // Core clock period in picoseconds
    localparam int unsigned CORE_PERIOD_PS = 8000;

    // First data after burst rise, least time
    localparam int unsigned FIRST_DATA_DELAY_PS = 12800;
    localparam int unsigned FIRST_DATA_CYCLES   = (FIRST_DATA_DELAY_PS + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;

    // Transmit-active release after burst fall, longest time
    localparam int unsigned TXACT_OFF_MAX_PS = 16000;
    localparam int unsigned TXACT_OFF_CYCLES = (TXACT_OFF_MAX_PS / CORE_PERIOD_PS) < 1 ? 1
                                             : (TXACT_OFF_MAX_PS / CORE_PERIOD_PS);

    // Temperature period in oscillator ticks (128 ms at 2.15 MHz)
    localparam int unsigned TEMP_PERIOD_TICKS = 275200;

    // Duty extension: 32 steps
    localparam int unsigned DUTY_STEPS = 32;
    localparam int unsigned DUTY_W     = 5;

    // Bias code floor and converter widths
    localparam logic [7:0] BIAS_CODE_FLOOR = 8'h05;
    localparam int unsigned CODE_W = 8;
    localparam int unsigned TEMP_W = 7;

    // Nonvolatile map: high address bit picks bias table
    localparam logic MOD_TABLE_SEL  = 1'b0;
    localparam logic BIAS_TABLE_SEL = 1'b1;

    // FIFO entry layout: {burst, data}
    localparam int unsigned ENTRY_W   = 2;
    localparam int unsigned ENTRY_BIT_BURST = 1;
    localparam int unsigned ENTRY_BIT_DATA  = 0;
    localparam int unsigned FIFO_DEPTH = 16;

    // Operating modes
    typedef enum logic [1:0] {
        MODE_SELF_RUN = 2'b00,
        MODE_ADJUST   = 2'b01,
        MODE_NVM      = 2'b10,
        MODE_SHUTDOWN = 2'b11
    } mode_e;

    // Self-running sequencer
    typedef enum logic [2:0] {
        SEQ_IDLE      = 3'b000,
        SEQ_CONVERT   = 3'b001,
        SEQ_FETCH_MOD = 3'b010,
        SEQ_WAIT_MOD  = 3'b011,
        SEQ_FETCH_BIAS= 3'b100,
        SEQ_WAIT_BIAS = 3'b101
    } seq_e;

endpackage

// file: logic/sync_2ff.sv
/*
 * Two-flop synchroniser for independent level bits.
 * Assumes each bit changes far slower than core_clk.
 */
`timescale 1ns/10ps
module sync_2ff #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // Next values: first stage is read only by the second
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // Register both stages
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule

// file: logic/stream_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; DEPTH must be a power of two.
 */
`timescale 1ns/10ps
module stream_fifo #(
    parameter int unsigned WIDTH = 2,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      wr_d;
    logic [AW:0]      rd_q;
    logic [AW:0]      rd_d;
    logic             push;
    logic             pop;

    // Full when pointers differ only in the wrap bit
    always_comb begin
        in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
        out_valid = (wr_q != rd_q);
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        wr_d      = push ? wr_q + 1'b1 : wr_q;
        rd_d      = pop ? rd_q + 1'b1 : rd_q;
        out_data  = mem_q[rd_q[AW-1:0]];
    end

    // Pointers
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    // Storage, no reset needed
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

endmodule

// file: logic/burst_laser_driver_control.sv
/*
 * Burst laser driver control: gating, bias switching,
 * input and operating modes, feed-forward, shutdown.
 * Assumes async pins, a slow link clock, and
 * converters, ADC and memory outside.
 */
// Contract
// - Mod current to positive output on data 1, else negative.
// - Data forced to 0 while burst is 0.
// - Bias flows only while burst is 1.
// - Last data 1 at burst fall extends bias off, within 2 ns; tail_q is registered, so up to one 8 ns core clock later.
// - Select low: direct inputs; high: latched on link clock.
// - Power-on enters self-run: temperature, memory read, current feed.
// - Adjust mode uses register codes.
// - Memory mode accepts nonvolatile writes.
// - Supply drop enters shutdown, currents off.
// - Transmit-active drops within 16 ns of burst fall.
// - Duty extension: 32 steps of about 0.03 ns.
// - Latched: sample on link clock falling edge.
// - Latched: bias on within 2 link clocks of burst.
// - Bias code 0 turns bias off; 1 to 4 become 5.
`timescale 1ns/10ps
module burst_laser_driver_control #(
    parameter int unsigned TEMP_PERIOD_TICKS = laser_ctrl_pkg::TEMP_PERIOD_TICKS,
    parameter int unsigned FIFO_DEPTH        = laser_ctrl_pkg::FIFO_DEPTH
) (
    input  wire logic                              core_clk,
    input  wire logic                              rstn,
    input  wire logic                              input_select,
    input  wire logic                              tx_data_pos,
    input  wire logic                              tx_data_neg,
    input  wire logic                              burst_enable_pos,
    input  wire logic                              burst_enable_neg,
    input  wire logic                              link_clock_pos,
    input  wire logic                              link_clock_neg,
    input  wire logic                              transmit_disable,
    input  wire logic                              supply_ok,
    input  wire logic                              osc_level,
    input  wire logic                              pd_above_ref,
    input  wire logic [1:0]                        mode_req,
    input  wire logic [laser_ctrl_pkg::CODE_W-1:0] adj_mod_code,
    input  wire logic [laser_ctrl_pkg::CODE_W-1:0] adj_bias_code,
    input  wire logic [laser_ctrl_pkg::DUTY_W-1:0] duty_code,
    input  wire logic                              host_wr_strobe,
    input  wire logic [laser_ctrl_pkg::CODE_W-1:0] host_wr_addr,
    input  wire logic [laser_ctrl_pkg::CODE_W-1:0] host_wr_data,
    input  wire logic                              adc_done,
    input  wire logic [laser_ctrl_pkg::TEMP_W-1:0] adc_code,
    input  wire logic                              nvm_rd_valid,
    input  wire logic [laser_ctrl_pkg::CODE_W-1:0] nvm_rd_data,
    input  wire logic                              overflow_clear,
    output logic                                   mod_out_pos,
    output logic                                   mod_out_neg,
    output logic                                   bias_out,
    output logic      [laser_ctrl_pkg::CODE_W-1:0] mod_current_code,
    output logic      [laser_ctrl_pkg::CODE_W-1:0] bias_code,
    output logic      [laser_ctrl_pkg::DUTY_W-1:0] pulse_extend,
    output logic                                   bias_tail_extend,
    output logic                                   transmit_active,
    output logic                                   fifo_overflow,
    output logic                                   adc_start,
    output logic                                   nvm_rd_req,
    output logic                                   nvm_wr_req,
    output logic      [laser_ctrl_pkg::CODE_W-1:0] nvm_addr,
    output logic      [laser_ctrl_pkg::CODE_W-1:0] nvm_wr_data,
    output logic      [1:0]                        op_mode
);

    localparam int unsigned TW = $clog2(TEMP_PERIOD_TICKS + 1);

    // Synchronised pins: select, disable, supply, osc, pd, link clk, burst, data
    logic [7:0] pins_s;
    logic       sel_s, transmit_disable_s, supply_s, osc_s, pd_s, lclk_s, burst_s, data_s;

    sync_2ff #(.WIDTH(8)) u_pin_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .async_in ({input_select, transmit_disable, supply_ok, osc_level, pd_above_ref,
                    link_clock_pos & ~link_clock_neg, burst_enable_pos & ~burst_enable_neg,
                    tx_data_pos & ~tx_data_neg}),
        .sync_out (pins_s)
    );

    assign {sel_s, transmit_disable_s, supply_s, osc_s, pd_s, lclk_s, burst_s, data_s} = pins_s;

    // Mode state
    laser_ctrl_pkg::mode_e mode_q, mode_d;

    // Mode selection; supply drop overrides everything
    always_comb begin
        mode_d = mode_q;
        if (!supply_s) begin
            mode_d = laser_ctrl_pkg::MODE_SHUTDOWN;
        end else if (mode_q == laser_ctrl_pkg::MODE_SHUTDOWN) begin
            mode_d = laser_ctrl_pkg::MODE_SELF_RUN;
        end else if (mode_req != 2'b11) begin
            mode_d = laser_ctrl_pkg::mode_e'(mode_req);
        end
    end

    // Reset lands in self-running mode
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mode_q <= laser_ctrl_pkg::MODE_SELF_RUN;
        end else begin
            mode_q <= mode_d;
        end
    end

    // Drivers allowed only outside shutdown and transmit disable
    logic drive_en;
    assign drive_en = (mode_q != laser_ctrl_pkg::MODE_SHUTDOWN) && !transmit_disable_s;

    // Latched path: link clock falling edge pushes a sample
    logic lclk_prev_q, lclk_prev_d, lclk_fall;
    logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [laser_ctrl_pkg::ENTRY_W-1:0] fifo_out_data;

    always_comb begin
        lclk_prev_d = lclk_s;
        lclk_fall   = lclk_prev_q && !lclk_s && sel_s;
    end

    // Drain stalls while drivers are off, so the buffer can fill
    assign fifo_out_ready = drive_en;

    stream_fifo #(.WIDTH(laser_ctrl_pkg::ENTRY_W), .DEPTH(FIFO_DEPTH)) u_sample_fifo (
        .core_clk  (core_clk),
        .rstn      (rstn),
        .in_valid  (lclk_fall),
        .in_ready  (fifo_in_ready),
        .in_data   ({burst_s, data_s}),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // Latched burst/data and tracking state
    logic lat_burst_q, lat_burst_d, lat_data_q, lat_data_d;
    logic burst_prev_q, burst_prev_d, last_data_q, last_data_d;
    logic tail_q, tail_d, txact_q, txact_d, ovf_q, ovf_d;
    logic [laser_ctrl_pkg::DUTY_W-1:0] ext_q, ext_d;
    logic burst_raw, data_raw, burst_eff, data_eff;

    // Effective burst and data: raw pins when direct, FIFO stage when latched
    always_comb begin
        burst_raw = burst_enable_pos & ~burst_enable_neg;
        data_raw  = tx_data_pos & ~tx_data_neg;
        burst_eff = sel_s ? lat_burst_q : burst_raw;
        data_eff  = burst_eff & (sel_s ? lat_data_q : data_raw);
    end

    // Next values of the output stage
    always_comb begin
        lat_burst_d  = lat_burst_q;
        lat_data_d   = lat_data_q;
        if (fifo_out_valid && fifo_out_ready) begin
            lat_burst_d = fifo_out_data[laser_ctrl_pkg::ENTRY_BIT_BURST];
            lat_data_d  = fifo_out_data[laser_ctrl_pkg::ENTRY_BIT_DATA];
        end
        if (!sel_s) begin
            lat_burst_d = 1'b0;
            lat_data_d  = 1'b0;
        end
        burst_prev_d = burst_eff;
        last_data_d  = burst_eff ? data_eff : last_data_q;
        tail_d       = burst_prev_q && !burst_eff && last_data_q;
        ext_d        = duty_code;
        txact_d      = burst_eff && (txact_q || pd_s);
        ovf_d        = (lclk_fall && !fifo_in_ready) || (ovf_q && !overflow_clear);
    end

    // Register the output stage
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            lclk_prev_q  <= 1'b0;
            lat_burst_q  <= 1'b0;
            lat_data_q   <= 1'b0;
            burst_prev_q <= 1'b0;
            last_data_q  <= 1'b0;
            tail_q       <= 1'b0;
            ext_q        <= '0;
            txact_q      <= 1'b0;
            ovf_q        <= 1'b0;
        end else begin
            lclk_prev_q  <= lclk_prev_d;
            lat_burst_q  <= lat_burst_d;
            lat_data_q   <= lat_data_d;
            burst_prev_q <= burst_prev_d;
            last_data_q  <= last_data_d;
            tail_q       <= tail_d;
            ext_q        <= ext_d;
            txact_q      <= txact_d;
            ovf_q        <= ovf_d;
        end
    end

    // Bias code floor and off code
    function automatic logic [laser_ctrl_pkg::CODE_W-1:0] floor_bias(
        input logic [laser_ctrl_pkg::CODE_W-1:0] stored
    );
        if (stored != '0 && stored < laser_ctrl_pkg::BIAS_CODE_FLOOR) begin
            floor_bias = laser_ctrl_pkg::BIAS_CODE_FLOOR;
        end else begin
            floor_bias = stored;
        end
    endfunction

    // Self-running sequencer state
    laser_ctrl_pkg::seq_e seq_q, seq_d;
    logic [TW-1:0] tick_cnt_q, tick_cnt_d;
    logic          osc_prev_q, osc_prev_d, period_due;
    logic [laser_ctrl_pkg::TEMP_W-1:0] temp_q, temp_d;
    logic [laser_ctrl_pkg::CODE_W-1:0] run_mod_q, run_mod_d, stored_bias_code_q, stored_bias_code_d;

    // Oscillator-paced temperature, memory read and current feed
    always_comb begin
        seq_d              = seq_q;
        tick_cnt_d         = tick_cnt_q;
        osc_prev_d         = osc_s;
        temp_d             = temp_q;
        run_mod_d          = run_mod_q;
        stored_bias_code_d = stored_bias_code_q;
        period_due         = (tick_cnt_q == '0);
        if (osc_s && !osc_prev_q) begin
            tick_cnt_d = period_due ? TW'(TEMP_PERIOD_TICKS - 1) : tick_cnt_q - 1'b1;
        end
        unique case (seq_q)
            laser_ctrl_pkg::SEQ_IDLE: begin
                if (mode_q == laser_ctrl_pkg::MODE_SELF_RUN && period_due && osc_s && !osc_prev_q) begin
                    seq_d = laser_ctrl_pkg::SEQ_CONVERT;
                end
            end
            laser_ctrl_pkg::SEQ_CONVERT: begin
                if (adc_done) begin
                    temp_d = adc_code;
                    seq_d  = laser_ctrl_pkg::SEQ_FETCH_MOD;
                end
            end
            laser_ctrl_pkg::SEQ_FETCH_MOD: begin
                seq_d = laser_ctrl_pkg::SEQ_WAIT_MOD;
            end
            laser_ctrl_pkg::SEQ_WAIT_MOD: begin
                if (nvm_rd_valid) begin
                    run_mod_d = nvm_rd_data;
                    seq_d     = laser_ctrl_pkg::SEQ_FETCH_BIAS;
                end
            end
            laser_ctrl_pkg::SEQ_FETCH_BIAS: begin
                seq_d = laser_ctrl_pkg::SEQ_WAIT_BIAS;
            end
            laser_ctrl_pkg::SEQ_WAIT_BIAS: begin
                if (nvm_rd_valid) begin
                    stored_bias_code_d = nvm_rd_data;
                    seq_d              = laser_ctrl_pkg::SEQ_IDLE;
                end
            end
            default: begin
                seq_d = laser_ctrl_pkg::SEQ_IDLE;
            end
        endcase
        if (mode_q == laser_ctrl_pkg::MODE_SHUTDOWN) begin
            seq_d = laser_ctrl_pkg::SEQ_IDLE;
        end
    end

    // Sequencer registers
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            seq_q              <= laser_ctrl_pkg::SEQ_IDLE;
            tick_cnt_q         <= '0;
            osc_prev_q         <= 1'b0;
            temp_q             <= '0;
            run_mod_q          <= '0;
            stored_bias_code_q <= '0;
        end else begin
            seq_q              <= seq_d;
            tick_cnt_q         <= tick_cnt_d;
            osc_prev_q         <= osc_prev_d;
            temp_q             <= temp_d;
            run_mod_q          <= run_mod_d;
            stored_bias_code_q <= stored_bias_code_d;
        end
    end

    // Codes: registers in adjust mode, tables otherwise
    logic [laser_ctrl_pkg::CODE_W-1:0] src_mod, src_bias, mod_code_q, mod_code_d;
    logic [laser_ctrl_pkg::CODE_W-1:0] bias_code_q, bias_code_d;

    always_comb begin
        src_mod  = (mode_q == laser_ctrl_pkg::MODE_ADJUST) ? adj_mod_code : run_mod_q;
        src_bias = (mode_q == laser_ctrl_pkg::MODE_ADJUST) ? adj_bias_code : stored_bias_code_q;
        mod_code_d  = drive_en ? src_mod : '0;
        bias_code_d = drive_en ? floor_bias(src_bias) : '0;
    end

    // Code registers
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mod_code_q  <= '0;
            bias_code_q <= '0;
        end else begin
            mod_code_q  <= mod_code_d;
            bias_code_q <= bias_code_d;
        end
    end

    // Current switches; combinational so direct mode needs no clock edge
    always_comb begin
        mod_out_pos = drive_en && data_eff;
        mod_out_neg = drive_en && !data_eff;
        bias_out    = drive_en && burst_eff && (bias_code_q != '0);
    end

    // Memory requests: sequencer reads, host writes
    always_comb begin
        adc_start   = (seq_q == laser_ctrl_pkg::SEQ_CONVERT);
        nvm_rd_req  = (seq_q == laser_ctrl_pkg::SEQ_FETCH_MOD) || (seq_q == laser_ctrl_pkg::SEQ_FETCH_BIAS);
        nvm_wr_req  = (mode_q == laser_ctrl_pkg::MODE_NVM) && host_wr_strobe;
        nvm_wr_data = host_wr_data;
        if (mode_q == laser_ctrl_pkg::MODE_NVM) begin
            nvm_addr = host_wr_addr;
        end else if (seq_q == laser_ctrl_pkg::SEQ_FETCH_BIAS || seq_q == laser_ctrl_pkg::SEQ_WAIT_BIAS) begin
            nvm_addr = {laser_ctrl_pkg::BIAS_TABLE_SEL, temp_q};
        end else begin
            nvm_addr = {laser_ctrl_pkg::MOD_TABLE_SEL, temp_q};
        end
    end

    // Status and converter outputs
    assign mod_current_code = mod_code_q;
    assign bias_code        = bias_code_q;
    assign pulse_extend     = ext_q;
    assign bias_tail_extend = tail_q && drive_en;
    assign transmit_active  = txact_q && burst_eff;
    assign fifo_overflow    = ovf_q;
    assign op_mode          = mode_q;

endmodule

// file: verif/burst_laser_driver_control_asserts.sv
/* Checker: port-level properties of the laser driver control.
   Bound to the top module; sees its ports only. */
`timescale 1ns/10ps
module laser_chk (
    input wire logic       core_clk,
    input wire logic       rstn,
    input wire logic       input_select,
    input wire logic       tx_data_pos,
    input wire logic       tx_data_neg,
    input wire logic       burst_enable_pos,
    input wire logic       burst_enable_neg,
    input wire logic       supply_ok,
    input wire logic       transmit_disable,
    input wire logic [1:0] op_mode,
    input wire logic       mod_out_pos,
    input wire logic       mod_out_neg,
    input wire logic       bias_out,
    input wire logic       transmit_active,
    input wire logic [7:0] adj_bias_code,
    input wire logic [7:0] bias_code
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // Direct mode held for four edges
    sequence dir_s;
        !input_select [*4];
    endsequence
    a_mod_follow: assert property (dir_s ##0 mod_out_pos |-> tx_data_pos && !tx_data_neg)
        else $error("mod on without data");
    a_mod_excl: assert property (!(mod_out_pos && mod_out_neg))
        else $error("both mod outputs on");
    a_data_gate: assert property (dir_s ##0 !burst_enable_pos |-> !mod_out_pos)
        else $error("data not gated");
    a_bias_burst: assert property (dir_s ##0 bias_out |-> burst_enable_pos && !burst_enable_neg)
        else $error("bias on without burst");
    a_txact_drop: assert property (dir_s ##0 !burst_enable_pos |-> ##[0:2] !transmit_active)
        else $error("transmit active held");
    a_shut_off: assert property (!supply_ok [*4] |-> !mod_out_pos && !mod_out_neg && !bias_out)
        else $error("current on in shutdown");
    a_supply_drop: assert property (!supply_ok [*5] |-> op_mode == 2'b11)
        else $error("no shutdown on drop");
    a_bias_raise: assert property ((op_mode == 2'b01 && !transmit_disable && adj_bias_code == 8'h03) [*6]
        |-> bias_code == 8'h05) else $error("low code not raised");
    c_burst: cover property (dir_s ##0 bias_out ##1 !bias_out);
    c_shut: cover property (op_mode == 2'b11 ##1 op_mode == 2'b01);
    c_latch: cover property (input_select && bias_out);
endmodule
bind burst_laser_driver_control laser_chk chk_u (.*);

// file: verif/framer_model.sv
/* Framer model driving burst, data and link clock pins.
   Needs core_clk; the 160 ns link clock runs only inside frames. */
`timescale 1ns/10ps
module framer_model (
    input  wire logic core_clk,
    input  wire logic latched,
    input  wire logic frame,
    input  wire logic burst,
    input  wire logic data,
    output logic      tx_data_pos,
    output logic      tx_data_neg,
    output logic      burst_enable_pos,
    output logic      burst_enable_neg,
    output logic      link_clock_pos,
    output logic      link_clock_neg
);
    logic lclk = 1'b1, b_q = 1'b0, d_q = 1'b0;
    int   hold = 0;
    // Complementary pin pairs
    assign {burst_enable_pos, burst_enable_neg} = {b_q, ~b_q};
    assign {tx_data_pos, tx_data_neg} = {d_q, ~d_q};
    assign {link_clock_pos, link_clock_neg} = {lclk, ~lclk};
    // Link clock, offset from core_clk, still outside frames
    initial begin
        #3;
        forever #80 lclk = (latched && frame) ? ~lclk : lclk;
    end
    // Slot launch; first data two slots after burst rises
    task automatic launch();
        hold = (burst && !b_q) ? 2 : (hold > 0 ? hold - 1 : 0);
        b_q  = burst;
        d_q  = (hold == 0) ? data : 1'b0;
    endtask
    always @(negedge core_clk) if (!(latched && frame)) launch();
    always @(posedge lclk) if (latched && frame) launch();
endmodule

// file: verif/test_burst_laser_driver_control.sv
/* Testbench for the laser driver control with the framer model.
   Self-checking; random stimulus from a fixed xorshift seed. */
`timescale 1ns/10ps
module test_burst_laser_driver_control;
    logic       core_clk = 1'b0, rstn = 1'b0, input_select = 1'b0, transmit_disable = 1'b0, supply_ok = 1'b1, e;
    logic       osc_level = 1'b0, pd_above_ref = 1'b1, host_wr_strobe = 1'b0, adc_done = 1'b0, nvm_rd_valid = 1'b0;
    logic       overflow_clear = 1'b0, frame = 1'b0, burst = 1'b0, data = 1'b0, bias_tail_extend;
    logic [1:0] mode_req = 2'b01, op_mode;
    logic [7:0] adj_mod_code = 8'h00, adj_bias_code = 8'h40, host_wr_addr = 8'h00, host_wr_data = 8'h00;
    logic [7:0] nvm_rd_data = 8'h00, mod_current_code, bias_code, nvm_addr, nvm_wr_data;
    logic [6:0] adc_code = 7'h00;
    logic [4:0] duty_code = 5'h00, pulse_extend;
    logic       tx_data_pos, tx_data_neg, burst_enable_pos, burst_enable_neg, link_clock_pos, link_clock_neg;
    logic       mod_out_pos, mod_out_neg, bias_out, transmit_active, fifo_overflow, adc_start, nvm_rd_req, nvm_wr_req;
    logic [31:0] seed = 32'd11566, r;
    int         bad_count = 0, samples_checked = 0, i, n;
    logic [7:0] codes [6] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'hff};
    burst_laser_driver_control #(.TEMP_PERIOD_TICKS(4)) dut_u (.*);
    framer_model frm_u (.latched(input_select), .*);
    // Core and oscillator clocks
    initial forever #4 core_clk = ~core_clk;
    always #233 osc_level = ~osc_level;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [7:0] bias_map(input logic [7:0] c);
        return (c != 8'h00 && c < 8'h05) ? 8'h05 : c;
    endfunction
    task automatic chk(input logic ok);
        samples_checked++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("CHECK FAILED at %0t: mismatch", $time);
        end
    endtask
    task automatic results();
        $display("checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask
    // One table read answered a cycle after its request
    task automatic fetch(input logic [7:0] a, input logic [7:0] v);
        for (int k = 0; k < 40 && nvm_rd_req !== 1'b1; k++) tick();
        chk(nvm_rd_req === 1'b1 && nvm_addr === a);
        @(negedge core_clk);
        nvm_rd_data  <= v;
        nvm_rd_valid <= 1'b1;
        @(negedge core_clk);
        nvm_rd_valid <= 1'b0;
    endtask
    // Watchdog well beyond the expected run
    initial begin
        #200us;
        bad_count++;
        results();
    end
    initial begin
        repeat (12) @(negedge core_clk);
        rstn  <= 1'b1;
        burst <= 1'b1;
        // Adjust mode code table with burst on
        foreach (codes[k]) begin
            r = rnd();
            adj_bias_code <= codes[k];
            adj_mod_code  <= r[7:0];
            duty_code     <= r[12:8];
            repeat (10) @(negedge core_clk);
            chk(bias_code === bias_map(codes[k]));
            chk(bias_out === (codes[k] != 8'h00));
            chk(mod_current_code === r[7:0]);
            chk(pulse_extend === r[12:8]);
        end
        // Burst ending on a one
        data <= 1'b1;
        @(negedge core_clk);
        burst <= 1'b0;
        for (n = 0; n < 6 && bias_tail_extend !== 1'b1; n++) tick();
        chk(bias_tail_extend === 1'b1);
        // Direct mode: random data, bursts with gaps
        for (i = 0; i < 120; i++) begin
            r = rnd();
            burst <= (i % 24) < 16;
            data  <= r[0];
            tick();
            e = tx_data_pos & ~tx_data_neg & burst_enable_pos & ~burst_enable_neg;
            chk(mod_out_pos === e);
            chk(mod_out_neg === ~e);
            chk(bias_out === (burst_enable_pos & ~burst_enable_neg));
            @(negedge core_clk);
        end
        // Supply drop in mid-burst
        burst     <= 1'b1;
        supply_ok <= 1'b0;
        for (n = 0; n < 8 && op_mode !== 2'b11; n++) tick();
        chk(op_mode === 2'b11);
        chk({mod_out_pos, mod_out_neg, bias_out} === 3'b000);
        @(negedge core_clk);
        supply_ok    <= 1'b1;
        input_select <= 1'b1;
        data         <= 1'b1;
        frame        <= 1'b1;
        // Latched mode: bias follows a link clock fall
        for (n = 0; n < 120 && bias_out !== 1'b1; n++) tick();
        chk(bias_out === 1'b1);
        repeat (100) @(negedge core_clk);
        chk(mod_out_pos === 1'b1 && transmit_active === 1'b1);
        frame <= 1'b0;
        burst <= 1'b0;
        repeat (60) @(negedge core_clk);
        chk(bias_out === 1'b1);
        // Stalled output: FIFO overflows, then drains
        transmit_disable <= 1'b1;
        burst            <= 1'b1;
        frame            <= 1'b1;
        repeat (500) @(negedge core_clk);
        chk(fifo_overflow === 1'b1);
        transmit_disable <= 1'b0;
        overflow_clear   <= 1'b1;
        repeat (60) @(negedge core_clk);
        chk(fifo_overflow === 1'b0 && bias_out === 1'b1);
        overflow_clear <= 1'b0;
        frame          <= 1'b0;
        input_select   <= 1'b0;
        mode_req       <= 2'b00;
        // Self-running: convert, then two table reads
        for (n = 0; n < 900 && adc_start !== 1'b1; n++) tick();
        r = rnd();
        @(negedge core_clk);
        adc_code <= r[6:0];
        adc_done <= 1'b1;
        @(negedge core_clk);
        adc_done <= 1'b0;
        fetch({1'b0, r[6:0]}, r[15:8]);
        fetch({1'b1, r[6:0]}, 8'h02);
        repeat (4) @(negedge core_clk);
        chk(mod_current_code === r[15:8]);
        chk(bias_code === 8'h05);
        // Memory mode: host write passes through
        mode_req       <= 2'b10;
        host_wr_addr   <= r[23:16];
        host_wr_data   <= r[31:24];
        host_wr_strobe <= 1'b1;
        repeat (2) @(negedge core_clk);
        chk(nvm_wr_req === 1'b1 && nvm_addr === r[23:16] && nvm_wr_data === r[31:24]);
        results();
    end
endmodule
